// file: src/mcfl_link.sv
// command frame receiver, executor handshake and reply framer
`timescale 1ns/100ps
`include "mcfl_defs.svh"

// Function
// - command core is seven bytes: command, type, selector, four-byte value
// - serial command frame is nine bytes: address, core, checksum
// - value travels most significant byte first both directions
// - command checksum is byte sum of eight preceding bytes
// - serial reply: reply addr, module addr, status, command, value, checksum
// - reply checksum is byte sum of all other reply bytes
// - exactly one reply for each command frame carrying this module address (every frame in can mode)
// - reply sent only after executor reports the action finished; a checksum error reply goes out without the executor
// - device never transmits unsolicited; drives bus only for replies
// - strictly master/slave; device only responds
// - can mode: commands have no address or checksum byte
// - can mode: replies have no reply address or checksum byte, but keep the module address
// - status 100 when command executes without error
// - status 101 when command stored to program memory
// - errors: 1 checksum, 2 command, 3 type, 4 value, 5 locked, 6 unavailable

module mcfl_link #(
    parameter logic [7:0] MODULE_ADDR = `MCFL_MODULE_ADDR,
    parameter logic [7:0] REPLY_ADDR  = `MCFL_REPLY_ADDR,
    parameter int         FIFO_DEPTH  = `MCFL_FIFO_DEPTH
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       can_mode,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    output logic            rx_ready,
    output logic [7:0]      tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    output logic            tx_drive,
    output logic            cmd_valid,
    output logic [7:0]      cmd_code,
    output logic [7:0]      cmd_type,
    output logic [7:0]      cmd_select,
    output logic [31:0]     cmd_value,
    input  wire logic       exe_done,
    input  wire logic [7:0] exe_status,
    input  wire logic [31:0] exe_value
);
    // ------------------------------------------------------------
    // receive side
    // ------------------------------------------------------------
    mcfl_pkg::mcfl_state_t state;
    logic [3:0]  rx_idx;
    logic [7:0]  rx_sum;
    logic        addr_ok;
    logic        sum_bad;
    logic [3:0]  rx_last;
    logic        rx_take;
    logic [7:0]  st_reg;
    logic [31:0] val_reg;
    logic [3:0]  tx_idx;
    logic [3:0]  tx_last;
    logic [7:0]  tx_sum;
    logic [7:0]  next_byte;
    logic        f_valid;
    logic        f_ready;
    logic        frame_end;

    assign rx_last  = can_mode ? `MCFL_CORE_BYTES - 4'd1 : `MCFL_SERIAL_BYTES - 4'd1;
    assign rx_ready = (state == mcfl_pkg::MCFL_RX);
    assign rx_take  = rx_valid && rx_ready;
    assign frame_end = rx_take && (rx_idx == rx_last);

    function automatic logic [3:0] core_pos(input logic [3:0] idx, input logic can);
        core_pos = can ? idx : idx - 4'd1;
    endfunction

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_idx  <= '0;
            rx_sum  <= '0;
            addr_ok <= 1'b0;
        end else if (rx_take) begin
            rx_idx <= frame_end ? 4'd0 : rx_idx + 4'd1;
            rx_sum <= frame_end ? 8'h00 : rx_sum + rx_data;
            if (rx_idx == 4'd0) begin
                addr_ok <= can_mode || (rx_data == MODULE_ADDR);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmd_code   <= '0;
            cmd_type   <= '0;
            cmd_select <= '0;
            cmd_value  <= '0;
        end else if (rx_take && !(rx_idx == 4'd0 && !can_mode) && !(rx_idx == 4'd8)) begin
            case (core_pos(rx_idx, can_mode))
                4'd0: cmd_code <= rx_data;
                4'd1: cmd_type <= rx_data;
                4'd2: cmd_select <= rx_data;
                default: cmd_value <= {cmd_value[23:0], rx_data};
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state     <= mcfl_pkg::MCFL_RX;
            cmd_valid <= 1'b0;
            sum_bad   <= 1'b0;
            st_reg    <= '0;
            val_reg   <= '0;
        end else begin
            cmd_valid <= 1'b0;
            case (state)
                mcfl_pkg::MCFL_RX: begin
                    if (frame_end && (can_mode || addr_ok || rx_idx == 4'd0)) begin
                        sum_bad <= !can_mode && (rx_sum != rx_data);
                        if (!can_mode && (rx_sum != rx_data)) begin
                            st_reg  <= `MCFL_ST_CHECKSUM;
                            val_reg <= '0;
                            state   <= mcfl_pkg::MCFL_TX;
                        end else begin
                            cmd_valid <= 1'b1;
                            state     <= mcfl_pkg::MCFL_WAIT;
                        end
                    end
                end
                mcfl_pkg::MCFL_WAIT: begin
                    // reply only after the action finished
                    if (exe_done) begin
                        st_reg  <= exe_status;
                        val_reg <= exe_value;
                        state   <= mcfl_pkg::MCFL_TX;
                    end
                end
                mcfl_pkg::MCFL_TX: begin
                    if (f_valid && f_ready && tx_idx == tx_last) begin
                        state <= mcfl_pkg::MCFL_EXEC;
                    end
                end
                mcfl_pkg::MCFL_EXEC: begin
                    // wait until the fifo has drained so the bus is free again
                    if (!tx_valid) begin
                        state <= mcfl_pkg::MCFL_RX;
                    end
                end
                default: state <= mcfl_pkg::MCFL_RX;
            endcase
        end
    end

    // ------------------------------------------------------------
    // reply framer
    // ------------------------------------------------------------
    // can reply keeps the module address, so it is seven bytes long
    assign tx_last = can_mode ? `MCFL_CORE_BYTES - 4'd1 : `MCFL_SERIAL_BYTES - 4'd1;
    assign f_valid = (state == mcfl_pkg::MCFL_TX);

    // reply byte order; can drops framing bytes
    always_comb begin
        next_byte = 8'h00;
        case (can_mode ? tx_idx + 4'd1 : tx_idx)
            4'd0: next_byte = REPLY_ADDR;
            4'd1: next_byte = MODULE_ADDR;
            // status as reported: 100, 101 or an error code
            4'd2: next_byte = st_reg;
            4'd3: next_byte = cmd_code;
            4'd4: next_byte = val_reg[31:24];
            4'd5: next_byte = val_reg[23:16];
            4'd6: next_byte = val_reg[15:8];
            4'd7: next_byte = val_reg[7:0];
            4'd8: next_byte = tx_sum;
            default: next_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_idx <= '0;
            tx_sum <= '0;
        end else if (f_valid && f_ready) begin
            tx_idx <= (tx_idx == tx_last) ? 4'd0 : tx_idx + 4'd1;
            tx_sum <= (tx_idx == tx_last) ? 8'h00 : tx_sum + next_byte;
        end
    end

    // bus driven only while reply bytes are pending
    assign tx_drive = (state == mcfl_pkg::MCFL_TX) || (state == mcfl_pkg::MCFL_EXEC);

    mcfl_fifo #(
        .WIDTH (`MCFL_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_data   (next_byte),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_no_unsolicited:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_valid |-> tx_drive)
        else $error("reply byte outside reply phase");

    a_one_reply:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_valid |-> (state == mcfl_pkg::MCFL_WAIT) && (tx_idx == 4'd0))
        else $error("command did not await its reply");

    a_reply_after_done:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == mcfl_pkg::MCFL_WAIT && !exe_done) |=> !f_valid)
        else $error("reply started before execution done");

    a_status_copy:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == mcfl_pkg::MCFL_WAIT && exe_done) |=> (st_reg == $past(exe_status)))
        else $error("status not taken from executor");

    a_sum_error:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (frame_end && !can_mode && addr_ok && rx_sum != rx_data && state == mcfl_pkg::MCFL_RX)
        |=> (st_reg == `MCFL_ST_CHECKSUM) && !cmd_valid)
        else $error("checksum error not reported");

    a_foreign_addr:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (frame_end && !can_mode && !addr_ok && rx_idx != 4'd0) |=> (state == mcfl_pkg::MCFL_RX))
        else $error("foreign frame answered");

    a_echo_cmd:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (f_valid && (can_mode ? tx_idx == 4'd2 : tx_idx == 4'd3)) |-> next_byte == cmd_code)
        else $error("command number not echoed");

    a_frame_len:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_valid |-> $past(frame_end) && ($past(rx_idx) == (can_mode ? 4'd6 : 4'd8)))
        else $error("command issued before the frame was complete");

    a_sum_status:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (f_valid && sum_bad) |-> (st_reg == `MCFL_ST_CHECKSUM) && (val_reg == '0))
        else $error("checksum reply carries wrong status or value");

    a_value_copy:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == mcfl_pkg::MCFL_WAIT && exe_done) |=> (val_reg == $past(exe_value)))
        else $error("reply value not taken from executor");

    // helper: reply bytes handed to the fifo since the link last listened
    logic [3:0] push_cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            push_cnt <= '0;
        end else if (state == mcfl_pkg::MCFL_RX) begin
            push_cnt <= '0;
        end else if (f_valid && f_ready) begin
            push_cnt <= push_cnt + 4'd1;
        end
    end

    a_reply_len:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == mcfl_pkg::MCFL_EXEC)
        |-> (push_cnt == (can_mode ? `MCFL_CORE_BYTES : `MCFL_SERIAL_BYTES)))
        else $error("reply length wrong for the link");

endmodule

// ----------------------------------------------------------------
// reply byte fifo
// ----------------------------------------------------------------
module mcfl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

// file: src/mcfl_defs.svh
// constants for the command frame link: frame layout, status codes, sizes
`ifndef MCFL_DEFS_SVH
`define MCFL_DEFS_SVH

`define MCFL_CORE_BYTES    4'd7
`define MCFL_SERIAL_BYTES  4'd9
`define MCFL_VALUE_BYTES   4'd4
`define MCFL_REPLY_ADDR    8'h02
`define MCFL_MODULE_ADDR   8'h01

`define MCFL_ST_OK         8'h64
`define MCFL_ST_STORED     8'h65
`define MCFL_ST_CHECKSUM   8'h01
`define MCFL_ST_BAD_CMD    8'h02
`define MCFL_ST_BAD_TYPE   8'h03
`define MCFL_ST_BAD_VALUE  8'h04
`define MCFL_ST_LOCKED     8'h05
`define MCFL_ST_NOT_AVAIL  8'h06

`define MCFL_FIFO_DEPTH    8
`define MCFL_FIFO_WIDTH    8

`endif

// file: src/mcfl_pkg.sv
// types for the command frame link
package mcfl_pkg;

    typedef enum logic [2:0] {
        MCFL_RX,
        MCFL_EXEC,
        MCFL_WAIT,
        MCFL_TX
    } mcfl_state_t;

endpackage

// file: src/mcfl_fifo.sv
// holds no code: the reply byte fifo module stands beside the link logic in mcfl_link.sv

// file: tb/mcfl_host.sv
// host side model: sends command bytes and collects reply bytes
`timescale 1ns/100ps

module mcfl_host (
    input  wire logic       clk_sys,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    int         stall = 0;
    logic [7:0] rep [0:8];

    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end

    task automatic send(input logic [7:0] fr [0:8], input int s, input int n);
        for (int i = s; i < s + n; i++) begin
            rx_data = fr[i];
            rx_valid = 1'b1;
            while (rx_ready !== 1'b1) @(negedge clk_sys);
            @(negedge clk_sys);
        end
        rx_valid = 1'b0;
        // a released line must not keep showing the last byte
        rx_data = ~rx_data;
    endtask

    // slow host holds tx_ready low to let the fifo back up
    task automatic get(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (stall) @(negedge clk_sys);
            tx_ready = 1'b1;
            while (tx_valid !== 1'b1) @(negedge clk_sys);
            rep[i] = tx_data;
            @(negedge clk_sys);
            if (stall != 0 || i == n - 1) tx_ready = 1'b0;
        end
    endtask
endmodule

// file: tb/mcfl_link_test.sv
// self-checking bench for the command frame link
`timescale 1ns/100ps
`include "mcfl_defs.svh"

module mcfl_link_test;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        can_mode = 1'b0;
    logic        exe_done = 1'b0;
    logic [7:0]  exe_status = 8'h00;
    logic [31:0] exe_value = 32'h0;
    logic [7:0]  rx_data, tx_data, cmd_code, cmd_type, cmd_select;
    logic        rx_valid, rx_ready, tx_valid, tx_ready, tx_drive, cmd_valid;
    logic [31:0] cmd_value;
    int          n_fail = 0;
    int          compares = 0;
    int          n_cmd = 0;
    int          pend = 0;
    int          delay = 3;

    always #5 clk_sys = ~clk_sys;

    mcfl_link mcfl_link_i (.clk_sys(clk_sys), .rst_n(rst_n), .can_mode(can_mode),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_drive(tx_drive),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_type(cmd_type),
        .cmd_select(cmd_select), .cmd_value(cmd_value), .exe_done(exe_done),
        .exe_status(exe_status), .exe_value(exe_value));

    mcfl_host mcfl_host_i (.clk_sys(clk_sys), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // executor stand-in: finishes each action a few cycles after the command
    always @(negedge clk_sys) begin
        exe_done = (pend == 1);
        if (tx_valid === 1'b1) check(tx_drive, 1'b1);
        if (pend > 0) begin
            check(tx_valid, 1'b0);
            pend--;
        end
        if (cmd_valid === 1'b1) begin
            n_cmd++;
            pend = delay;
        end
    end

    task automatic run(input logic [7:0] adr, code, typ, input logic [31:0] val,
                       input logic [7:0] st, input logic [31:0] rv, input logic bad);
        logic [7:0]  f [0:8];
        logic [7:0]  e [0:8];
        logic [7:0]  sum;
        logic [31:0] v;
        int          n0;
        n0 = n_cmd;
        exe_status = st;
        exe_value = rv;
        f = '{adr, code, typ, typ + 8'h01, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++) sum += f[i];
        f[8] = bad ? ~sum : sum;
        if (can_mode) mcfl_host_i.send(f, 1, 7);
        else mcfl_host_i.send(f, 0, 9);
        v = bad ? 32'h0 : rv;
        e = '{`MCFL_REPLY_ADDR, `MCFL_MODULE_ADDR, bad ? `MCFL_ST_CHECKSUM : st, code,
              v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++) sum += e[i];
        e[8] = sum;
        if (adr != `MCFL_MODULE_ADDR && !can_mode) begin
            repeat (40) @(negedge clk_sys);
            check(tx_valid, 1'b0);
            check(tx_drive, 1'b0);
            check(n_cmd, n0);
        end else begin
            mcfl_host_i.get(can_mode ? 7 : 9);
            for (int i = 0; i < (can_mode ? 7 : 9); i++) begin
                check(mcfl_host_i.rep[i], e[i + (can_mode ? 1 : 0)]);
            end
            repeat (3) @(negedge clk_sys);
            check(tx_valid, 1'b0);
            check(n_cmd, n0 + (bad ? 0 : 1));
            if (!bad) check({cmd_code, cmd_type, cmd_select}, {code, typ, typ + 8'h01});
            if (!bad) check(cmd_value, val);
        end
        check(rx_ready, 1'b1);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset;
        check({rx_ready, tx_valid, cmd_valid, tx_drive}, 4'h8);
    endtask

    task automatic t_ok;
        run(`MCFL_MODULE_ADDR, 8'h05, 8'h04, 32'h0000c800, `MCFL_ST_OK, 32'h12345678, 1'b0);
    endtask

    // every executor status except 100, back to back, with a slow host backing up the fifo
    task automatic t_codes;
        logic [7:0] sts [0:5];
        sts = '{`MCFL_ST_STORED, `MCFL_ST_BAD_CMD, `MCFL_ST_BAD_TYPE, `MCFL_ST_BAD_VALUE,
                `MCFL_ST_LOCKED, `MCFL_ST_NOT_AVAIL};
        mcfl_host_i.stall = 3;
        delay = 1;
        for (int i = 0; i < 6; i++) run(`MCFL_MODULE_ADDR, 8'h80 + i, 8'hff, 32'hff00ff01,
            sts[i], 32'hfffffff0 + i, 1'b0);
        mcfl_host_i.stall = 0;
        delay = 4;
    endtask

    task automatic t_bad;
        run(`MCFL_MODULE_ADDR, 8'h06, 8'h01, 32'h80000001, `MCFL_ST_OK, 32'h5a5a5a5a, 1'b1);
    endtask

    task automatic t_foreign;
        run(8'h7f, 8'h03, 8'h00, 32'h0, `MCFL_ST_OK, 32'h0, 1'b0);
    endtask

    task automatic t_can;
        can_mode = 1'b1;
        run(`MCFL_MODULE_ADDR, 8'h0a, 8'h02, 32'hdeadbeef, `MCFL_ST_OK, 32'h01020304, 1'b0);
        can_mode = 1'b0;
    endtask

    // reset in mid-frame: the partial frame is forgotten, the next one is answered
    task automatic t_midreset;
        logic [7:0] f [0:8];
        int         n0;
        n0 = n_cmd;
        f = '{`MCFL_MODULE_ADDR, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h07};
        mcfl_host_i.send(f, 0, 4);
        rst_n = 1'b0;
        @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check({rx_ready, tx_valid, cmd_valid, tx_drive}, 4'h8);
        repeat (10) @(negedge clk_sys);
        check(n_cmd, n0);
        t_ok();
    endtask

    task automatic tally_and_finish;
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // --------------------------------------------------------------
    // sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_ok();
        t_codes();
        t_bad();
        t_foreign();
        t_can();
        t_midreset();
        tally_and_finish();
    end

    // about twelve frames of under a hundred cycles each, with wide margin
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule
